// >>> flash_seq_pkg.sv
`default_nettype none

package flash_seq_pkg;

    // register byte offsets
    localparam logic [7:0] CMD_AREA_OFS = 8'h00;
    localparam logic [7:0] START_ADDR_OFS = 8'h04;
    localparam logic [7:0] END_ADDR_OFS = 8'h08;
    localparam logic [7:0] POLICY_OFS = 8'h0c;
    localparam logic [7:0] ENTRY_OFS = 8'h10;
    localparam logic [7:0] FSTAT_OFS = 8'h14;
    localparam logic [7:0] ASTAT_OFS = 8'h18;

    // command codes
    localparam logic [7:0] AREA_ERASE_CODE = 8'h23;
    localparam logic [7:0] BLOCK_ERASE_CODE = 8'h20;
    localparam logic [7:0] PROGRAM_CODE = 8'he8;
    localparam logic [7:0] CONFIRM_CODE = 8'hd0;
    localparam logic [7:0] RESUME_CODE = 8'hd0;
    localparam logic [7:0] SUSPEND_CODE = 8'hb0;
    localparam logic [7:0] STATUS_CLEAR_CODE = 8'h50;

    // flash status field positions
    localparam int READY_BIT = 15;
    localparam int SUSPEND_READY_FLAG_BIT = 14;
    localparam int ERASE_SUSPENDED_FLAG_BIT = 13;
    localparam int PROGRAM_SUSPENDED_FLAG_BIT = 12;
    localparam int ILLEGAL_BIT = 11;
    localparam int ADDR_ERR_BIT = 10;
    // access status and policy register field positions
    localparam int LOCK_BIT = 4;
    localparam int POLICY_BIT = 0;

    // values after reset
    localparam logic POLICY_RESET = 1'b0;
    localparam logic [15:0] ENTRY_RESET = 16'h0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    // address map
    localparam logic [31:0] DATA_BASE = 32'h0000_0000;
    localparam logic [31:0] DATA_LAST = 32'h0003_ffff;
    localparam logic [31:0] EXT_BASE = 32'h0010_0000;
    localparam logic [31:0] EXT_LAST = 32'h0010_7fff;
    localparam int MACRO_SHIFT = 17;
    localparam int DATA_BLOCK_SHIFT = 12;
    localparam int EXT_BLOCK_SHIFT = 11;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_PULSE_NS = 8000;
    localparam int SUSPEND_READY_FLAG_DELAY_NS = 1000;
    localparam int SUSPEND_CUT_NS = 200;
    localparam int ERASE_PULSE_US = 1000;
    localparam int PROG_PULSE_CYCLES = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUSPEND_READY_FLAG_CYCLES = (SUSPEND_READY_FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SUSPEND_CUT_CYCLES = (SUSPEND_CUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_PULSE_CYCLES_DEF = (ERASE_PULSE_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_PULSES = 8'h02;
    localparam logic [7:0] ERASE_PULSES_PER_BLOCK = 8'h02;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROG,
        ST_ERASE,
        ST_SUSPENDING,
        ST_SUSPENDED
    } seq_state_t;

endpackage

`default_nettype wire

// >>> flash_erase_suspend_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module flash_erase_suspend_sequencer
    import flash_seq_pkg::*;
#(
    parameter int unsigned ERASE_PULSE_CYCLES = flash_seq_pkg::ERASE_PULSE_CYCLES_DEF
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic ready_out,
    output logic lock_out,
    output logic pulse_active,
    output logic read_mode
);
    import flash_seq_pkg::*;

    // range check shared by area and block erase; nested programming uses in_range
    function automatic logic range_ok(input logic [31:0] s, input logic [31:0] e);
        logic in_data;
        logic in_ext;
        in_data = (s >= DATA_BASE) && (e <= DATA_LAST) && (s <= e)
            && (s[31:MACRO_SHIFT] == e[31:MACRO_SHIFT]);
        in_ext = (s >= EXT_BASE) && (e <= EXT_LAST) && (s <= e)
            && (s[31:EXT_BLOCK_SHIFT] == e[31:EXT_BLOCK_SHIFT]);
        return in_data || in_ext;
    endfunction

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] s,
                                      input logic [31:0] e);
        return (a >= s) && (a <= e);
    endfunction

    seq_state_t state, next_state;
    logic [31:0] start_address_reg, next_start_address_reg;
    logic [31:0] end_address_reg, next_end_address_reg;
    logic erase_suspend_policy, next_erase_suspend_policy;
    logic [15:0] mode_entry_reg, next_mode_entry_reg;
    logic sequencer_ready_flag, next_sequencer_ready_flag;
    logic suspend_ready_flag, next_suspend_ready_flag;
    logic erase_suspended_flag, next_erase_suspended_flag;
    logic program_suspended_flag, next_program_suspended_flag;
    logic command_lock_flag, next_command_lock_flag;
    logic illegal_flag, next_illegal_flag;
    logic addr_err_flag, next_addr_err_flag;
    logic [7:0] pending_code, next_pending_code;
    logic pending, next_pending;
    logic op_erase, next_op_erase;
    logic nested_prog, next_nested_prog;
    logic cutting, next_cutting;
    logic pulse_cut_once, next_pulse_cut_once;
    logic [31:0] erase_lo, next_erase_lo;
    logic [31:0] erase_hi, next_erase_hi;
    logic [7:0] erase_left, next_erase_left;
    logic [31:0] erase_cnt, next_erase_cnt;
    logic [7:0] prog_left, next_prog_left;
    logic [31:0] prog_cnt, next_prog_cnt;
    logic [31:0] wait_cnt, next_wait_cnt;
    logic [31:0] reg_rdata_q, next_reg_rdata;
    logic next_pulse_active;

    logic cmd_wr;
    logic [7:0] code;
    logic [31:0] pulse_len;
    logic [31:0] pulse_cnt;
    logic pulse_end;
    logic [7:0] blocks;

    assign cmd_wr = reg_wr && (reg_addr == CMD_AREA_OFS);
    assign code = reg_wdata[7:0];
    assign pulse_len = op_erase && !nested_prog ? ERASE_PULSE_CYCLES : 32'(PROG_PULSE_CYCLES);
    assign pulse_cnt = op_erase && !nested_prog ? erase_cnt : prog_cnt;
    assign pulse_end = (pulse_cnt == pulse_len - 32'h1);
    // data area counts 4k blocks, an extended area erase covers one 2k block
    assign blocks = (start_address_reg >= EXT_BASE) ? 8'h01 :
        8'((end_address_reg >> DATA_BLOCK_SHIFT) - (start_address_reg >> DATA_BLOCK_SHIFT) + 32'h1);

    always_comb
    begin
        next_state = state;
        next_start_address_reg = start_address_reg;
        next_end_address_reg = end_address_reg;
        next_erase_suspend_policy = erase_suspend_policy;
        next_mode_entry_reg = mode_entry_reg;
        next_sequencer_ready_flag = sequencer_ready_flag;
        next_suspend_ready_flag = suspend_ready_flag;
        next_erase_suspended_flag = erase_suspended_flag;
        next_program_suspended_flag = program_suspended_flag;
        next_command_lock_flag = command_lock_flag;
        next_illegal_flag = illegal_flag;
        next_addr_err_flag = addr_err_flag;
        next_pending_code = pending_code;
        next_pending = pending;
        next_op_erase = op_erase;
        next_nested_prog = nested_prog;
        next_cutting = cutting;
        next_pulse_cut_once = pulse_cut_once;
        next_erase_lo = erase_lo;
        next_erase_hi = erase_hi;
        next_erase_left = erase_left;
        next_erase_cnt = erase_cnt;
        next_prog_left = prog_left;
        next_prog_cnt = prog_cnt;
        next_wait_cnt = wait_cnt;

        // running operation timing
        unique case (state)
            ST_IDLE, ST_SUSPENDED:
            begin
            end
            ST_PROG, ST_ERASE:
            begin
                if (!nested_prog && !suspend_ready_flag)
                begin
                    if (wait_cnt == 32'(SUSPEND_READY_FLAG_CYCLES - 1))
                        next_suspend_ready_flag = 1'b1;
                    else
                        next_wait_cnt = wait_cnt + 32'h1;
                end
                if (state == ST_PROG)
                    next_prog_cnt = pulse_end ? 32'h0 : prog_cnt + 32'h1;
                else
                    next_erase_cnt = pulse_end ? 32'h0 : erase_cnt + 32'h1;
                if (pulse_end)
                begin
                    if (state == ST_PROG)
                        next_prog_left = prog_left - 8'h1;
                    else
                    begin
                        next_erase_left = erase_left - 8'h1;
                        // a fresh pulse may be cut again
                        next_pulse_cut_once = 1'b0;
                    end
                    if ((state == ST_PROG ? prog_left : erase_left) == 8'h1)
                    begin
                        next_suspend_ready_flag = 1'b0;
                        next_sequencer_ready_flag = 1'b1;
                        next_state = nested_prog ? ST_SUSPENDED : ST_IDLE;
                        next_nested_prog = 1'b0;
                    end
                end
            end
            ST_SUSPENDING:
            begin
                if (cutting)
                begin
                    // pulse cut, reapplied from its start on resume
                    if (wait_cnt == 32'(SUSPEND_CUT_CYCLES - 1))
                    begin
                        next_erase_cnt = 32'h0;
                        next_pulse_cut_once = 1'b1;
                        next_cutting = 1'b0;
                        next_sequencer_ready_flag = 1'b1;
                        next_state = ST_SUSPENDED;
                    end
                    else
                        next_wait_cnt = wait_cnt + 32'h1;
                end
                else
                begin
                    if (op_erase)
                        next_erase_cnt = pulse_end ? 32'h0 : erase_cnt + 32'h1;
                    else
                        next_prog_cnt = pulse_end ? 32'h0 : prog_cnt + 32'h1;
                    if (pulse_end)
                    begin
                        if (op_erase)
                        begin
                            next_erase_left = erase_left - 8'h1;
                            next_pulse_cut_once = 1'b0;
                        end
                        else
                            next_prog_left = prog_left - 8'h1;
                        next_sequencer_ready_flag = 1'b1;
                        // last pulse done means plain completion
                        if ((op_erase ? erase_left : prog_left) == 8'h1)
                            next_state = ST_IDLE;
                        else
                        begin
                            next_erase_suspended_flag = op_erase;
                            next_program_suspended_flag = !op_erase;
                            next_state = ST_SUSPENDED;
                        end
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase

        if (reg_wr)
        begin
            unique case (reg_addr)
                START_ADDR_OFS: next_start_address_reg = reg_wdata;
                END_ADDR_OFS: next_end_address_reg = reg_wdata;
                POLICY_OFS: next_erase_suspend_policy = reg_wdata[POLICY_BIT];
                ENTRY_OFS: next_mode_entry_reg = reg_wdata[15:0];
                default:
                begin
                end
            endcase
        end

        if (cmd_wr)
        begin
            if (command_lock_flag)
            begin
                // only status clear gets through a lock
                if (code == STATUS_CLEAR_CODE)
                begin
                    next_command_lock_flag = 1'b0;
                    next_illegal_flag = 1'b0;
                    next_addr_err_flag = 1'b0;
                end
            end
            else if (pending)
            begin
                next_pending = 1'b0;
                // second access must be the confirm code
                if (code != CONFIRM_CODE)
                    next_illegal_flag = 1'b1;
                else if (pending_code == PROGRAM_CODE)
                begin
                    // nested write must avoid the erase target
                    if (state == ST_SUSPENDED &&
                        in_range(start_address_reg, erase_lo, erase_hi))
                        next_illegal_flag = 1'b1;
                    else
                    begin
                        next_sequencer_ready_flag = 1'b0;
                        next_nested_prog = (state == ST_SUSPENDED);
                        next_op_erase = (state == ST_SUSPENDED);
                        next_prog_left = PROG_PULSES;
                        next_prog_cnt = 32'h0;
                        next_wait_cnt = 32'h0;
                        next_state = ST_PROG;
                    end
                end
                else if (!range_ok(start_address_reg, end_address_reg))
                    next_addr_err_flag = 1'b1;
                else
                begin
                    next_sequencer_ready_flag = 1'b0;
                    next_op_erase = 1'b1;
                    next_erase_lo = start_address_reg;
                    next_erase_hi = end_address_reg;
                    next_erase_left = (pending_code == AREA_ERASE_CODE) ?
                        8'(blocks * ERASE_PULSES_PER_BLOCK) : ERASE_PULSES_PER_BLOCK;
                    next_erase_cnt = 32'h0;
                    next_pulse_cut_once = 1'b0;
                    next_wait_cnt = 32'h0;
                    next_state = ST_ERASE;
                end
            end
            else if (code == AREA_ERASE_CODE || code == BLOCK_ERASE_CODE ||
                     code == PROGRAM_CODE)
            begin
                // only programming is allowed under erase suspension
                if (mode_entry_reg != 16'h0000 && (state == ST_IDLE ||
                    (state == ST_SUSPENDED && erase_suspended_flag && code == PROGRAM_CODE)))
                begin
                    next_pending = 1'b1;
                    next_pending_code = code;
                end
                else
                    next_illegal_flag = 1'b1;
            end
            else if (code == SUSPEND_CODE)
            begin
                // only a running operation can be suspended
                // an operation finishing this cycle is left to complete
                if ((state == ST_PROG || state == ST_ERASE) && !nested_prog &&
                    next_state == state)
                begin
                    if (suspend_ready_flag)
                    begin
                        next_suspend_ready_flag = 1'b0;
                        next_wait_cnt = 32'h0;
                        next_state = ST_SUSPENDING;
                        // cut only a fresh erase pulse in priority mode
                        if (state == ST_ERASE && !erase_suspend_policy && !pulse_cut_once)
                        begin
                            next_cutting = 1'b1;
                            next_erase_suspended_flag = 1'b1;
                        end
                    end
                    else
                        next_illegal_flag = 1'b1;
                end
            end
            else if (code == RESUME_CODE)
            begin
                if (state != ST_SUSPENDED || !(erase_suspended_flag || program_suspended_flag))
                    next_illegal_flag = 1'b1;
                else
                begin
                    // ready and suspended flags cleared, operation restarts
                    next_sequencer_ready_flag = 1'b0;
                    next_erase_suspended_flag = 1'b0;
                    next_program_suspended_flag = 1'b0;
                    next_wait_cnt = 32'h0;
                    next_state = op_erase ? ST_ERASE : ST_PROG;
                end
            end
            else if (code == STATUS_CLEAR_CODE)
            begin
                next_illegal_flag = 1'b0;
                next_addr_err_flag = 1'b0;
            end
            else
                next_illegal_flag = 1'b1;
        end

        // any error sets the lock; set wins over clear
        if ((next_illegal_flag && !illegal_flag) || (next_addr_err_flag && !addr_err_flag))
            next_command_lock_flag = 1'b1;

        next_pulse_active = (next_state == ST_PROG) || (next_state == ST_ERASE) ||
            (next_state == ST_SUSPENDING && !next_cutting);

        next_reg_rdata = 32'h0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                START_ADDR_OFS: next_reg_rdata = start_address_reg;
                END_ADDR_OFS: next_reg_rdata = end_address_reg;
                POLICY_OFS: next_reg_rdata[POLICY_BIT] = erase_suspend_policy;
                ENTRY_OFS: next_reg_rdata[15:0] = mode_entry_reg;
                FSTAT_OFS:
                begin
                    next_reg_rdata[READY_BIT] = sequencer_ready_flag;
                    next_reg_rdata[SUSPEND_READY_FLAG_BIT] = suspend_ready_flag;
                    next_reg_rdata[ERASE_SUSPENDED_FLAG_BIT] = erase_suspended_flag;
                    next_reg_rdata[PROGRAM_SUSPENDED_FLAG_BIT] = program_suspended_flag;
                    next_reg_rdata[ILLEGAL_BIT] = illegal_flag;
                    next_reg_rdata[ADDR_ERR_BIT] = addr_err_flag;
                end
                ASTAT_OFS: next_reg_rdata[LOCK_BIT] = command_lock_flag;
                default: next_reg_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            start_address_reg <= ADDR_RESET;
            end_address_reg <= ADDR_RESET;
            erase_suspend_policy <= POLICY_RESET;
            mode_entry_reg <= ENTRY_RESET;
            sequencer_ready_flag <= 1'b1;
            suspend_ready_flag <= 1'b0;
            erase_suspended_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
            command_lock_flag <= 1'b0;
            illegal_flag <= 1'b0;
            addr_err_flag <= 1'b0;
            pending_code <= 8'h00;
            pending <= 1'b0;
            op_erase <= 1'b0;
            nested_prog <= 1'b0;
            cutting <= 1'b0;
            pulse_cut_once <= 1'b0;
            erase_lo <= ADDR_RESET;
            erase_hi <= ADDR_RESET;
            erase_left <= 8'h00;
            erase_cnt <= 32'h0;
            prog_left <= 8'h00;
            prog_cnt <= 32'h0;
            wait_cnt <= 32'h0;
            reg_rdata_q <= 32'h0;
            ready_out <= 1'b1;
            lock_out <= 1'b0;
            pulse_active <= 1'b0;
            read_mode <= 1'b1;
        end
        else
        begin
            state <= next_state;
            start_address_reg <= next_start_address_reg;
            end_address_reg <= next_end_address_reg;
            erase_suspend_policy <= next_erase_suspend_policy;
            mode_entry_reg <= next_mode_entry_reg;
            sequencer_ready_flag <= next_sequencer_ready_flag;
            suspend_ready_flag <= next_suspend_ready_flag;
            erase_suspended_flag <= next_erase_suspended_flag;
            program_suspended_flag <= next_program_suspended_flag;
            command_lock_flag <= next_command_lock_flag;
            illegal_flag <= next_illegal_flag;
            addr_err_flag <= next_addr_err_flag;
            pending_code <= next_pending_code;
            pending <= next_pending;
            op_erase <= next_op_erase;
            nested_prog <= next_nested_prog;
            cutting <= next_cutting;
            pulse_cut_once <= next_pulse_cut_once;
            erase_lo <= next_erase_lo;
            erase_hi <= next_erase_hi;
            erase_left <= next_erase_left;
            erase_cnt <= next_erase_cnt;
            prog_left <= next_prog_left;
            prog_cnt <= next_prog_cnt;
            wait_cnt <= next_wait_cnt;
            reg_rdata_q <= next_reg_rdata;
            ready_out <= next_sequencer_ready_flag;
            lock_out <= next_command_lock_flag;
            pulse_active <= next_pulse_active;
            // cleared entry register means read mode
            read_mode <= (next_mode_entry_reg == 16'h0000);
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule

`default_nettype wire

// >>> flash_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
module flash_seq_props
    import flash_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ready_out,
    input wire logic lock_out,
    input wire logic pulse_active,
    input wire logic read_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic cmd_wr;
    logic clr_wr;
    logic [15:0] entry_val;
    assign cmd_wr = reg_wr && reg_addr == CMD_AREA_OFS;
    assign clr_wr = cmd_wr && reg_wdata[7:0] == STATUS_CLEAR_CODE;
    assign entry_val = reg_wdata[15:0];
    a_busy_cause: assert property ($fell(ready_out) |-> $past(cmd_wr))
        else $error("ready fell without a command");
    a_busy_pulse: assert property ($fell(ready_out) |-> ##[0:2] pulse_active)
        else $error("busy without a pulse");
    a_lock_cause: assert property ($rose(lock_out) |-> $past(cmd_wr))
        else $error("lock rose without a command");
    a_lock_release: assert property (lock_out && clr_wr |=> !lock_out)
        else $error("status clear kept the lock");
    a_lock_holds: assert property (lock_out && !clr_wr |=> lock_out)
        else $error("lock dropped by itself");
    a_pulse_busy: assert property (pulse_active |-> !ready_out)
        else $error("ready during a pulse");
    a_entry_mode: assert property (reg_wr && reg_addr == ENTRY_OFS
        |=> read_mode == ($past(entry_val) == 16'h0))
        else $error("read mode wrong after entry write");
    a_start_pulse: assert property ($rose(pulse_active) |-> !ready_out && !lock_out)
        else $error("pulse started while idle or locked");
    cover property ($rose(lock_out));
    cover property ($fell(ready_out));
    cover property (lock_out && clr_wr);
endmodule
bind flash_erase_suspend_sequencer flash_seq_props u_props (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ready_out(ready_out), .lock_out(lock_out),
    .pulse_active(pulse_active), .read_mode(read_mode));
`default_nettype wire

// >>> tb_flash_erase_suspend_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_erase_suspend_sequencer;
    import flash_seq_pkg::*;
    logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic ready_out, lock_out, pulse_active, read_mode;
    int mismatches = 0, samples_checked = 0;
    logic [31:0] bad [4] = '{32'h2000, 32'h1000, 32'h1f000, 32'h20fff};
    flash_erase_suspend_sequencer #(.ERASE_PULSE_CYCLES(50)) dut_u (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ready_out(ready_out), .lock_out(lock_out),
        .pulse_active(pulse_active), .read_mode(read_mode));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    // strobe then a gap cycle, so a following call never reassigns it in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask
    task automatic wait_ready();
        int i;
        i = 0;
        @(negedge clk);
        while (ready_out !== 1'b1 && i < 3000)
        begin
            @(negedge clk);
            i++;
        end
        @(posedge clk);
        if (i >= 3000)
        begin
            mismatches++;
            $display("[ERR] %0t ready never returned", $time);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(FSTAT_OFS);
        chk(32'(d[15:10]), 32'h20);
        rd(8'hfc);
        chk(d, 32'h0);
        wr(ENTRY_OFS, 32'h1);
        chk(32'(read_mode), 32'h0);
        wr(CMD_AREA_OFS, 32'(RESUME_CODE));
        rd(FSTAT_OFS);
        chk(32'({lock_out, d[11]}), 32'h3);
        wr(CMD_AREA_OFS, 32'(STATUS_CLEAR_CODE));
        chk(32'(lock_out), 32'h0);
        $display("illegal resume done");
        for (int k = 0; k < 4; k += 2)
        begin
            wr(START_ADDR_OFS, bad[k]);
            wr(END_ADDR_OFS, bad[k+1]);
            wr(CMD_AREA_OFS, 32'(AREA_ERASE_CODE));
            wr(CMD_AREA_OFS, 32'(CONFIRM_CODE));
            rd(FSTAT_OFS);
            chk(32'({lock_out, d[10]}), 32'h3);
            wr(CMD_AREA_OFS, 32'(STATUS_CLEAR_CODE));
        end
        $display("address errors done");
        for (int p = 0; p < 2; p++)
        begin
            wr(POLICY_OFS, 32'(p));
            wr(START_ADDR_OFS, 32'h0);
            wr(END_ADDR_OFS, 32'h7fff);
            wr(CMD_AREA_OFS, 32'(AREA_ERASE_CODE));
            wr(CMD_AREA_OFS, 32'(CONFIRM_CODE));
            chk(32'(pulse_active), 32'h1);
            rd(FSTAT_OFS);
            chk(32'(d[15:14]), 32'h0);
            repeat (130) @(posedge clk);
            rd(FSTAT_OFS);
            chk(32'(d[14]), 32'h1);
            chk(32'(lock_out), 32'h0);
            wr(CMD_AREA_OFS, 32'(SUSPEND_CODE));
            rd(FSTAT_OFS);
            chk(32'(d[14]), 32'h0);
            wait_ready();
            chk(32'(pulse_active), 32'h0);
            rd(FSTAT_OFS);
            chk(32'(d[15:12]), 32'ha);
            wr(ENTRY_OFS, 32'h0);
            chk(32'(read_mode), 32'h1);
            wr(ENTRY_OFS, 32'h1);
            // nested write outside the suspended erase range
            wr(START_ADDR_OFS, 32'h10000);
            wr(CMD_AREA_OFS, 32'(PROGRAM_CODE));
            wr(CMD_AREA_OFS, 32'(CONFIRM_CODE));
            wait_ready();
            rd(FSTAT_OFS);
            chk(32'(d[15:11]), 32'h14);
            wr(CMD_AREA_OFS, 32'(RESUME_CODE));
            chk(32'(ready_out), 32'h0);
            wait_ready();
            rd(FSTAT_OFS);
            chk(32'(d[15:11]), 32'h10);
            $display("suspend with policy %0d done", p);
        end
        wr(START_ADDR_OFS, 32'h10000);
        wr(CMD_AREA_OFS, 32'(PROGRAM_CODE));
        wr(CMD_AREA_OFS, 32'(CONFIRM_CODE));
        chk(32'({ready_out, pulse_active}), 32'h1);
        repeat (130) @(posedge clk);
        wr(CMD_AREA_OFS, 32'(SUSPEND_CODE));
        chk(32'(pulse_active), 32'h1);
        wait_ready();
        rd(FSTAT_OFS);
        chk(32'(d[15:12]), 32'h9);
        wr(CMD_AREA_OFS, 32'(RESUME_CODE));
        rd(FSTAT_OFS);
        chk(32'(d[15:12]), 32'h0);
        wait_ready();
        rd(FSTAT_OFS);
        chk(32'(d[15:11]), 32'h10);
        $display("program suspend done");
        wr(CMD_AREA_OFS, 32'(SUSPEND_CODE));
        chk(32'({lock_out, ready_out}), 32'h1);
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
